// >>> hw/ctdr_defines.svh
// constants of the composite timer data register block
// assumes a byte-wide register port with 12-bit byte addresses
`ifndef CTDR_DEFINES_SVH
`define CTDR_DEFINES_SVH

`define CTDR_ADDR_HIGH_DATA 12'hF94
`define CTDR_ADDR_LOW_DATA 12'hF95
`define CTDR_ADDR_CTRL 12'hF96
`define CTDR_ADDR_STATUS 12'hF97

`define CTDR_DATA_RESET 8'h00
`define CTDR_ZERO8 8'h00
`define CTDR_MAX16 16'hFFFF
`define CTDR_MAX8 16'h00FF

`define CTDR_CTRL_RUN_BIT 0
`define CTDR_CTRL_WIDTH_BIT 1
`define CTDR_CTRL_FSEL_LSB 4
`define CTDR_STAT_FULL_BIT 0
`define CTDR_STAT_OUT_BIT 1

`define CTDR_FSEL_INTERVAL 4'h0
`define CTDR_FSEL_PWM_FIXED 4'h1
`define CTDR_FSEL_PWM_VAR 4'h2
`define CTDR_FSEL_MEAS_HIGH 4'h3
`define CTDR_FSEL_MEAS_LOW 4'h4
`define CTDR_FSEL_MEAS_CYCLE 4'h5
`define CTDR_FSEL_MEAS_HIGH_CYCLE 4'h9
`define CTDR_FSEL_CAP_RISE 4'hA
`define CTDR_FSEL_CAP_FALL 4'hB
`define CTDR_FSEL_CAP_BOTH 4'hC

`endif

// >>> hw/ctdr_pkg.sv
// types of the composite timer data register block
// assumes ctdr_defines.svh carries the numeric encodings
package ctdr_pkg;

    typedef enum logic [2:0] {
        CTDR_MODE_INTERVAL,
        CTDR_MODE_PWM_FIXED,
        CTDR_MODE_PWM_VAR,
        CTDR_MODE_MEASURE,
        CTDR_MODE_CAPTURE,
        CTDR_MODE_IDLE
    } ctdr_mode_t;

endpackage : ctdr_pkg

// >>> hw/ctdr_data_regs.sv
// composite timer channel: data registers, comparator latches and counters
// assumes a single clk domain and a plain byte register port; measIn is an async pin
// How it works
// - interval start copies data into latch and starts counting
// - interval match reloads latch, clears counter, keeps counting
// - interval and pwm reads return the live counter
// - fixed pwm: start high, low on match, reload on overflow
// - variable pwm: low register is low width, high is period; start low
// - variable pwm: low match drives high; period match reloads both latches
// - measurement done with buffer empty copies counter to data and sets buffer full
// - combined mode moves high pulse despite full, withholds cycle result
// - writes in measurement and capture overwrite the stored result
// - capture copies counter to data on the selected edge
// - buffered high read also snaps low value into read buffer
// - buffered high write fills write buffer; low write commits both
// - width select joins both timers into one 16-bit timer, except in variable pwm, whose start clears it
`include "ctdr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ctdr_data_regs (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdata,
    // timer pins and status
    input wire logic measIn,
    output logic timerOut,
    output logic bufferFull
);

    logic rstMeta;
    logic rstN;
    logic measSync1;
    logic measLvl;
    logic measPrev;
    logic runBit;
    logic runPrev;
    logic widthSel;
    logic [3:0] funcSel;
    logic [7:0] dataLo;
    logic [7:0] dataHi;
    logic [7:0] writeBuf;
    logic [7:0] readBuf;
    logic [7:0] latchLo;
    logic [7:0] latchHi;
    logic [15:0] cnt;
    logic armed;

    ctdr_pkg::ctdr_mode_t mode;
    logic buffered;
    logic start;
    logic [15:0] cmpVal;
    logic [15:0] maxVal;
    logic rise, fall;
    logic selHi, selLo, wrHi, wrLo, rdHi, rdLo, wrCtrl;
    logic measStart, measDone, hpDone, capEdge;
    logic takeResult, setFull, clrFull, lowWriteOk;
    logic [7:0] srcHi, srcLo;

    function automatic ctdr_pkg::ctdr_mode_t modeOf(input logic [3:0] f);
        case (f)
            `CTDR_FSEL_INTERVAL: return ctdr_pkg::CTDR_MODE_INTERVAL;
            `CTDR_FSEL_PWM_FIXED: return ctdr_pkg::CTDR_MODE_PWM_FIXED;
            `CTDR_FSEL_PWM_VAR: return ctdr_pkg::CTDR_MODE_PWM_VAR;
            `CTDR_FSEL_MEAS_HIGH, `CTDR_FSEL_MEAS_LOW, `CTDR_FSEL_MEAS_CYCLE,
            `CTDR_FSEL_MEAS_HIGH_CYCLE: return ctdr_pkg::CTDR_MODE_MEASURE;
            `CTDR_FSEL_CAP_RISE, `CTDR_FSEL_CAP_FALL,
            `CTDR_FSEL_CAP_BOTH: return ctdr_pkg::CTDR_MODE_CAPTURE;
            default: return ctdr_pkg::CTDR_MODE_IDLE;
        endcase
    endfunction : modeOf

    // one 16-bit value, or the low byte alone in 8-bit operation
    function automatic logic [15:0] widen(input logic wide, input logic [7:0] hi, input logic [7:0] lo);
        return wide ? {hi, lo} : {`CTDR_ZERO8, lo};
    endfunction : widen

    function automatic logic [15:0] incMasked(input logic [15:0] v, input logic [15:0] m);
        return (v + 16'h0001) & m;
    endfunction : incMasked

    // reset release and pin synchronisers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            measSync1 <= 1'b0;
            measLvl <= 1'b0;
            measPrev <= 1'b0;
            runPrev <= 1'b0;
        end else begin
            measSync1 <= measIn;
            measLvl <= measSync1;
            measPrev <= measLvl;
            runPrev <= runBit;
        end
    end

    // decode
    always_comb begin
        mode = modeOf(funcSel);
        buffered = widthSel | (mode == ctdr_pkg::CTDR_MODE_PWM_VAR);
        start = runBit & ~runPrev;
        cmpVal = widen(widthSel, latchHi, latchLo);
        maxVal = widthSel ? `CTDR_MAX16 : `CTDR_MAX8;
        rise = measLvl & ~measPrev;
        fall = ~measLvl & measPrev;
        selHi = (addr == `CTDR_ADDR_HIGH_DATA);
        selLo = (addr == `CTDR_ADDR_LOW_DATA);
        wrHi = wrStrobe & selHi;
        wrLo = wrStrobe & selLo;
        rdHi = rdStrobe & selHi;
        rdLo = rdStrobe & selLo;
        wrCtrl = wrStrobe & (addr == `CTDR_ADDR_CTRL);
        measStart = 1'b0;
        measDone = 1'b0;
        hpDone = 1'b0;
        capEdge = 1'b0;
        case (funcSel)
            `CTDR_FSEL_MEAS_HIGH: begin
                measStart = rise;
                measDone = fall & armed;
            end
            `CTDR_FSEL_MEAS_LOW: begin
                measStart = fall;
                measDone = rise & armed;
            end
            `CTDR_FSEL_MEAS_CYCLE: begin
                measStart = rise;
                measDone = rise & armed;
            end
            `CTDR_FSEL_MEAS_HIGH_CYCLE: begin
                measStart = rise;
                measDone = rise & armed;
                hpDone = fall & armed;
            end
            `CTDR_FSEL_CAP_RISE: capEdge = rise;
            `CTDR_FSEL_CAP_FALL: capEdge = fall;
            `CTDR_FSEL_CAP_BOTH: capEdge = rise | fall;
            default: capEdge = 1'b0;
        endcase
        // high pulse passes even when full, cycle result waits
        setFull = runBit & ~start & ((measDone & ~bufferFull) | hpDone);
        takeResult = setFull | (runBit & ~start & capEdge);
        // low read ends the buffered pair read
        clrFull = rdLo & (mode == ctdr_pkg::CTDR_MODE_MEASURE);
        // zero compare is dropped in interval mode
        lowWriteOk = ~((mode == ctdr_pkg::CTDR_MODE_INTERVAL) &
                       (buffered ? ({writeBuf, wdata} == 16'h0000) : (wdata == `CTDR_ZERO8)));
        // interval and pwm modes show the live counter
        if (mode == ctdr_pkg::CTDR_MODE_INTERVAL || mode == ctdr_pkg::CTDR_MODE_PWM_FIXED ||
            mode == ctdr_pkg::CTDR_MODE_PWM_VAR) begin
            srcHi = cnt[15:8];
            srcLo = cnt[7:0];
        end else begin
            srcHi = dataHi;
            srcLo = dataLo;
        end
    end

    // control register
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            runBit <= 1'b0;
            widthSel <= 1'b0;
            funcSel <= `CTDR_FSEL_INTERVAL;
        end else begin
            if (wrCtrl) begin
                runBit <= wdata[`CTDR_CTRL_RUN_BIT];
            end
            // mode fields are frozen while the timer runs, except that a variable pwm start clears width select
            if (wrCtrl && !runBit) begin
                widthSel <= wdata[`CTDR_CTRL_WIDTH_BIT];
                funcSel <= wdata[`CTDR_CTRL_FSEL_LSB +: 4];
            end else if (start && mode == ctdr_pkg::CTDR_MODE_PWM_VAR) begin
                widthSel <= 1'b0;
            end
        end
    end

    // data registers and write buffer
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            dataLo <= `CTDR_DATA_RESET;
            dataHi <= `CTDR_DATA_RESET;
            writeBuf <= `CTDR_DATA_RESET;
        end else begin
            if (wrHi && buffered) begin
                writeBuf <= wdata;
            end
            // a fresh result wins over a software write in the same cycle
            if (takeResult) begin
                dataLo <= cnt[7:0];
                if (widthSel) begin
                    dataHi <= cnt[15:8];
                end
            end else if (wrLo && lowWriteOk) begin
                dataLo <= wdata;
                if (buffered) begin
                    dataHi <= writeBuf;
                end
            end else if (wrHi && !buffered && lowWriteOk) begin
                dataHi <= wdata;
            end
        end
    end

    // buffer-full flag, set wins over clear
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            bufferFull <= 1'b0;
        end else if (setFull) begin
            bufferFull <= 1'b1;
        end else if (clrFull) begin
            bufferFull <= 1'b0;
        end
    end

    // timer core: counters, latches, output
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cnt <= 16'h0000;
            latchLo <= `CTDR_DATA_RESET;
            latchHi <= `CTDR_DATA_RESET;
            timerOut <= 1'b0;
            armed <= 1'b0;
        end else if (start) begin
            latchLo <= dataLo;
            latchHi <= dataHi;
            cnt <= 16'h0000;
            armed <= 1'b0;
            timerOut <= (mode == ctdr_pkg::CTDR_MODE_PWM_FIXED);
        end else if (runBit) begin
            unique case (mode)
                ctdr_pkg::CTDR_MODE_INTERVAL: begin
                    if (cnt == cmpVal) begin
                        latchLo <= dataLo;
                        latchHi <= dataHi;
                        cnt <= 16'h0000;
                        timerOut <= ~timerOut;
                    end else begin
                        cnt <= incMasked(cnt, maxVal);
                    end
                end
                ctdr_pkg::CTDR_MODE_PWM_FIXED: begin
                    if (cnt == maxVal) begin
                        latchLo <= dataLo;
                        latchHi <= dataHi;
                        cnt <= 16'h0000;
                        timerOut <= 1'b1;
                    end else begin
                        if (cnt == cmpVal) begin
                            timerOut <= 1'b0;
                        end
                        cnt <= incMasked(cnt, maxVal);
                    end
                end
                ctdr_pkg::CTDR_MODE_PWM_VAR: begin
                    // low byte counts the low width, high byte the period
                    if (cnt[15:8] == latchHi) begin
                        latchLo <= dataLo;
                        latchHi <= dataHi;
                        cnt <= 16'h0000;
                        timerOut <= 1'b0;
                    end else begin
                        cnt[15:8] <= cnt[15:8] + 8'h01;
                        if (cnt[7:0] == latchLo) begin
                            timerOut <= 1'b1;
                        end else begin
                            cnt[7:0] <= cnt[7:0] + 8'h01;
                        end
                    end
                end
                ctdr_pkg::CTDR_MODE_MEASURE: begin
                    if (measStart) begin
                        cnt <= 16'h0000;
                        armed <= 1'b1;
                    end else begin
                        cnt <= incMasked(cnt, maxVal);
                    end
                end
                ctdr_pkg::CTDR_MODE_CAPTURE: cnt <= incMasked(cnt, maxVal);
                ctdr_pkg::CTDR_MODE_IDLE: cnt <= cnt;
            endcase
        end
    end

    // register reads, data valid the cycle after the strobe only
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdata <= `CTDR_ZERO8;
            readBuf <= `CTDR_DATA_RESET;
        end else begin
            rdata <= `CTDR_ZERO8;
            if (rdHi) begin
                rdata <= srcHi;
                if (buffered) begin
                    readBuf <= srcLo;
                end
            end else if (rdLo) begin
                rdata <= buffered ? readBuf : srcLo;
            end else if (rdStrobe && addr == `CTDR_ADDR_CTRL) begin
                rdata <= {funcSel, 2'b00, widthSel, runBit};
            end else if (rdStrobe && addr == `CTDR_ADDR_STATUS) begin
                rdata <= {6'b000000, timerOut, bufferFull};
            end
        end
    end

endmodule : ctdr_data_regs

`default_nettype wire

// >>> verification/ctdr_data_regs_checker.sv
// checker for the composite timer data register block
// assumes it is bound to ctdr_data_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "ctdr_defines.svh"

module ctdr_data_regs_checker (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [7:0] rdata,
    // timer pins and status
    input wire logic measIn,
    input wire logic timerOut,
    input wire logic bufferFull
);
    logic run;
    logic [3:0] fsel;
    logic prevIn;
    logic [3:0] since;
    wire logic ctlWr = wrStrobe && addr == `CTDR_ADDR_CTRL;
    wire logic start = ctlWr && wdata[0] && !run;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // shadow of run and function select; mode is frozen while running
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run <= 1'b0;
            fsel <= 4'h0;
        end else if (ctlWr) begin
            run <= wdata[0];
            if (!run) begin
                fsel <= wdata[7:4];
            end
        end
    end

    // cycles since the pin last changed, saturating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prevIn <= 1'b0;
            since <= 4'hF;
        end else begin
            prevIn <= measIn;
            since <= (measIn != prevIn) ? 4'h0 : ((since == 4'hF) ? 4'hF : since + 4'h1);
        end
    end

    read_idle_a: assert property (!$past(rdStrobe) |-> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    status_mirror_a: assert property ($past(rdStrobe && addr == `CTDR_ADDR_STATUS)
        |-> rdata[1:0] == {$past(timerOut), $past(bufferFull)})
        else $error("status read does not mirror output and flag");
    full_clear_a: assert property ($fell(bufferFull) |-> $past(rdStrobe && addr == `CTDR_ADDR_LOW_DATA))
        else $error("buffer full cleared without a low data read");
    full_cause_a: assert property ($rose(bufferFull) |-> since <= 4'h7)
        else $error("buffer full set with no recent pin edge");
    timer_nofull_a: assert property (fsel <= `CTDR_FSEL_PWM_VAR |-> !$rose(bufferFull))
        else $error("buffer full set in interval or pwm mode");
    capture_nofull_a: assert property (fsel >= `CTDR_FSEL_CAP_RISE && fsel <= `CTDR_FSEL_CAP_BOTH
        |-> !$rose(bufferFull))
        else $error("buffer full set in capture mode");
    fixed_start_a: assert property (start && wdata[7:4] == `CTDR_FSEL_PWM_FIXED |-> ##2 timerOut [*4])
        else $error("fixed pwm did not start high");
    var_start_a: assert property (start && wdata[7:4] == `CTDR_FSEL_PWM_VAR |-> ##2 !timerOut [*2])
        else $error("variable pwm did not start low");
endmodule : ctdr_data_regs_checker

bind ctdr_data_regs ctdr_data_regs_checker u_checker (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata), .measIn(measIn), .timerOut(timerOut),
    .bufferFull(bufferFull));

`default_nettype wire

// >>> verification/test_ctdr_data_regs.sv
// self-checking bench for the composite timer data register block
// assumes ctdr_data_regs with its checker bound; bench drives all input ports
`timescale 1ns/1ps
`default_nettype none
`include "ctdr_defines.svh"
`define CHK(a, e) chk((a), (e))

module test_ctdr_data_regs;
    logic clk, nrst, wrStrobe, rdStrobe, measIn, timerOut, bufferFull;
    logic [11:0] addr;
    logic [7:0] wdata, rdata, v, w;
    int err_count = 0;
    int checks = 0;
    int n;

    ctdr_data_regs u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdata(rdata), .measIn(measIn), .timerOut(timerOut), .bufferFull(bufferFull));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task chk(input logic [15:0] a, input logic [15:0] e);
        checks++;
        if (a !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask : chk

    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask : wr

    task rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task rdc(input logic [11:0] a, input logic [7:0] e);
        rd(a, v);
        `CHK(16'(v), 16'(e));
    endtask : rdc

    task near(input logic [7:0] x, input int e);
        `CHK(16'(x >= e - 1 && x <= e + 1), 16'h0001);
    endtask : near

    // mode written stopped, then started when r is set
    task ctl(input logic [3:0] f, input logic wd, input logic r);
        wr(`CTDR_ADDR_CTRL, {f, 2'b00, wd, 1'b0});
        if (r) wr(`CTDR_ADDR_CTRL, {f, 2'b00, wd, 1'b1});
    endtask : ctl

    // length in clocks of the next whole run of timerOut at level lv
    task span(input logic lv, output int c);
        int i;
        c = 0;
        for (i = 0; i < 600 && timerOut !== !lv; i++) @(posedge clk);
        for (i = 0; i < 600 && timerOut !== lv; i++) @(posedge clk);
        for (i = 0; i < 600 && timerOut === lv; i++) begin
            @(posedge clk);
            c++;
        end
    endtask : span

    task pulse(input int hi, input int lo);
        @(posedge clk);
        measIn <= 1'b1;
        repeat (hi) @(posedge clk);
        measIn <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask : pulse

    task t_reset;
        rdc(`CTDR_ADDR_HIGH_DATA, `CTDR_DATA_RESET);
        rdc(`CTDR_ADDR_LOW_DATA, `CTDR_DATA_RESET);
        rdc(`CTDR_ADDR_STATUS, 8'h00);
        rdc(12'h123, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task t_interval;
        ctl(`CTDR_FSEL_INTERVAL, 1'b0, 1'b0);
        wr(`CTDR_ADDR_LOW_DATA, 8'h05);
        ctl(`CTDR_FSEL_INTERVAL, 1'b0, 1'b1);
        span(1'b1, n);
        `CHK(16'(n), 16'h0006);
        rd(`CTDR_ADDR_LOW_DATA, v);
        rd(`CTDR_ADDR_LOW_DATA, w);
        `CHK(16'(w), 16'((v + 2) % 6));
        wr(`CTDR_ADDR_LOW_DATA, 8'h00);
        span(1'b0, n);
        span(1'b1, n);
        `CHK(16'(n), 16'h0006);
        wr(`CTDR_ADDR_LOW_DATA, 8'h02);
        span(1'b0, n);
        span(1'b1, n);
        `CHK(16'(n), 16'h0003);
        ctl(`CTDR_FSEL_INTERVAL, 1'b0, 1'b0);
        $display("test interval done");
    endtask : t_interval

    task t_pwm;
        ctl(`CTDR_FSEL_PWM_FIXED, 1'b0, 1'b0);
        wr(`CTDR_ADDR_LOW_DATA, 8'h3F);
        ctl(`CTDR_FSEL_PWM_FIXED, 1'b0, 1'b1);
        span(1'b1, n);
        `CHK(16'(n), 16'h0040);
        span(1'b0, n);
        `CHK(16'(n), 16'h00C0);
        ctl(`CTDR_FSEL_PWM_VAR, 1'b1, 1'b0);
        wr(`CTDR_ADDR_HIGH_DATA, 8'h09);
        wr(`CTDR_ADDR_LOW_DATA, 8'h03);
        ctl(`CTDR_FSEL_PWM_VAR, 1'b1, 1'b1);
        span(1'b0, n);
        `CHK(16'(n), 16'h0004);
        span(1'b1, n);
        `CHK(16'(n), 16'h0006);
        ctl(`CTDR_FSEL_PWM_VAR, 1'b0, 1'b0);
        $display("test pwm done");
    endtask : t_pwm

    task t_buffer;
        ctl(`CTDR_FSEL_MEAS_HIGH, 1'b1, 1'b0);
        wr(`CTDR_ADDR_HIGH_DATA, 8'h12);
        rdc(`CTDR_ADDR_HIGH_DATA, 8'h09);
        wr(`CTDR_ADDR_LOW_DATA, 8'h34);
        rdc(`CTDR_ADDR_HIGH_DATA, 8'h12);
        wr(`CTDR_ADDR_LOW_DATA, 8'h78);
        rdc(`CTDR_ADDR_LOW_DATA, 8'h34);
        rdc(`CTDR_ADDR_HIGH_DATA, 8'h12);
        rdc(`CTDR_ADDR_LOW_DATA, 8'h78);
        $display("test buffer done");
    endtask : t_buffer

    task t_measure;
        ctl(`CTDR_FSEL_MEAS_HIGH, 1'b0, 1'b1);
        pulse(20, 10);
        `CHK(16'(bufferFull), 16'h0001);
        pulse(30, 10);
        rd(`CTDR_ADDR_LOW_DATA, v);
        near(v, 20);
        `CHK(16'(bufferFull), 16'h0000);
        pulse(30, 10);
        rd(`CTDR_ADDR_LOW_DATA, v);
        near(v, 30);
        ctl(`CTDR_FSEL_MEAS_HIGH_CYCLE, 1'b0, 1'b1);
        pulse(10, 15);
        pulse(12, 15);
        rd(`CTDR_ADDR_LOW_DATA, v);
        near(v, 12);
        ctl(`CTDR_FSEL_MEAS_HIGH_CYCLE, 1'b0, 1'b0);
        $display("test measure done");
    endtask : t_measure

    task t_capture;
        ctl(`CTDR_FSEL_CAP_RISE, 1'b0, 1'b1);
        repeat (30) @(posedge clk);
        pulse(5, 8);
        rd(`CTDR_ADDR_LOW_DATA, v);
        rd(`CTDR_ADDR_LOW_DATA, w);
        `CHK(16'(w), 16'(v));
        `CHK(16'(v != 8'h00), 16'h0001);
        wr(`CTDR_ADDR_LOW_DATA, 8'h77);
        rdc(`CTDR_ADDR_LOW_DATA, 8'h77);
        ctl(`CTDR_FSEL_CAP_RISE, 1'b0, 1'b0);
        $display("test capture done");
    endtask : t_capture

    // low pulse measurement, then a 16-bit high pulse read as a buffered pair
    task t_wide;
        ctl(`CTDR_FSEL_MEAS_LOW, 1'b0, 1'b1);
        pulse(10, 20);
        pulse(10, 5);
        rd(`CTDR_ADDR_LOW_DATA, v);
        near(v, 20);
        ctl(`CTDR_FSEL_MEAS_LOW, 1'b0, 1'b0);
        ctl(`CTDR_FSEL_MEAS_HIGH, 1'b1, 1'b1);
        pulse(300, 10);
        rdc(`CTDR_ADDR_HIGH_DATA, 8'h01);
        `CHK(16'(bufferFull), 16'h0001);
        rd(`CTDR_ADDR_LOW_DATA, v);
        near(v, 8'h2C);
        `CHK(16'(bufferFull), 16'h0000);
        ctl(`CTDR_FSEL_MEAS_HIGH, 1'b1, 1'b0);
        $display("test wide done");
    endtask : t_wide

    task end_of_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_of_test();
    end

    initial begin
        nrst = 1'b0;
        addr = 12'h000;
        wdata = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        measIn = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_interval();
        t_pwm();
        t_buffer();
        t_measure();
        t_capture();
        t_wide();
        end_of_test();
    end
endmodule : test_ctdr_data_regs

`default_nettype wire
